// ===== design/coef_if.sv
// interface: scaling request and answer between control and scaler
`timescale 1ns/1ps
interface coef_if;
    logic [23:0] raw;
    logic [23:0] offset;
    logic [23:0] gain;
    logic [2:0] range;
    logic bipolar;
    logic [23:0] scaled;
    modport ctrl (output raw, offset, gain, range, bipolar, input scaled);
    modport scaler (input raw, offset, gain, range, bipolar, output scaled);
endinterface

// ===== design/conv_pkg.sv
// package: register map, field layouts and constants of the converter control
package conv_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_CTRL1 = 8'h08;
    localparam logic [7:0] ADDR_DECIM = 8'h0C;
    localparam logic [7:0] ADDR_EXCIT = 8'h10;
    localparam logic [7:0] ADDR_PRES = 8'h14;
    localparam logic [7:0] ADDR_POFF = 8'h18;
    localparam logic [7:0] ADDR_PGAIN = 8'h1C;
    localparam logic [7:0] ADDR_AOFF = 8'h20;
    localparam logic [7:0] ADDR_AGAIN = 8'h24;
    localparam logic [7:0] ADDR_ARES = 8'h28;
    localparam logic [7:0] ADDR_SCALED = 8'h2C;
    // result widths
    localparam int RES_W = 24;
    localparam int NARROW_W = 16;
    localparam int AUX_W = 16;
    // mode register fields
    localparam int MD_LSB = 0;
    localparam logic [2:0] MD_IDLE = 3'h0;
    localparam logic [2:0] MD_SYS_ZERO = 3'h6;
    localparam logic [2:0] MD_SYS_FULL = 3'h7;
    localparam int MODE_BIPOLAR_BIT = 4;
    localparam int MODE_AUX_BIT = 5;
    localparam logic [7:0] MODE_RESET = 8'h08;
    // control one: gain range field
    localparam int RANGE_LSB = 0;
    localparam logic [2:0] RANGE_NARROWEST = 3'h0;
    localparam logic [2:0] RANGE_WIDEST = 3'h7;
    localparam logic [7:0] CTRL1_RESET = 8'h07;
    // status bits
    localparam int ST_PDONE = 7;
    localparam int ST_ADONE = 6;
    localparam int ST_CAL = 5;
    localparam int ST_NOREF = 4;
    localparam int ST_ERR = 3;
    localparam logic [7:0] DECIM_RESET = 8'h45;
    localparam logic [23:0] MID_SCALE = 24'h80_0000;
    localparam logic [23:0] POFF_RESET = 24'h00_0000;
    localparam logic [23:0] PGAIN_RESET = 24'h80_0000;
    localparam logic [15:0] AOFF_RESET = 16'h0000;
    localparam logic [15:0] AGAIN_RESET = 16'h8000;
    // excitation code bits: [1:0] source A route, [3:2] source B route
    localparam logic [1:0] ROUTE_PIN1 = 2'h1;
    localparam logic [1:0] ROUTE_PIN2 = 2'h2;
    // power-up wait
    localparam real POWERUP_MS = 0.5;
    localparam real CLK_MHZ = 100.0;
    localparam int POWERUP_CYC = int'(POWERUP_MS * 1000.0 * CLK_MHZ);
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== design/excitation_router.sv
// decoding of the excitation control code into per-pin current sources
`timescale 1ns/1ps
module excitation_router (
    input wire logic [3:0] code,
    output logic [1:0] pin_one_srcs,
    output logic [1:0] pin_two_srcs
);
    // each 200 uA source routes to one pin; both on one pin give 400 uA
    assign pin_one_srcs = {code[3:2] == conv_pkg::ROUTE_PIN1,
                           code[1:0] == conv_pkg::ROUTE_PIN1};
    assign pin_two_srcs = {code[3:2] == conv_pkg::ROUTE_PIN2,
                           code[1:0] == conv_pkg::ROUTE_PIN2};
endmodule // excitation_router

// ===== design/result_scaler.sv
// combinational scaling of filter words by the calibration coefficients
`timescale 1ns/1ps
module result_scaler (
    coef_if.scaler c
);
    wire logic [24:0] diff;
    wire logic [48:0] prod;
    wire logic [24:0] norm;
    wire logic [24:0] biased;
    // offset taken off before the gain multiply
    assign diff = {1'b0, c.raw} - {1'b0, c.offset};
    // gain normalised so that 800000 is unity
    assign prod = {{24{diff[24]}}, diff} * {25'h0, c.gain};
    assign norm = prod[47:23];
    // bipolar is offset binary around mid-scale
    assign biased = c.bipolar ? norm + {1'b0, conv_pkg::MID_SCALE} : norm;
    // clamp to the code range; unipolar is straight binary
    assign c.scaled = biased[24] ? (c.bipolar ? 24'h00_0000 : 24'hFF_FFFF)
                                 : biased[23:0];
endmodule // result_scaler

// ===== design/sd_conv_ctrl.sv
// converter control: calibration, gain range, coding, registers over axi-lite
// Summary of operation
// - writing 110 to the mode field starts a system zero-scale calibration
// - writing 111 to the mode field starts a system full-scale calibration
// - bipolar zero-scale calibration maps zero input to code 800000
// - three-bit range field picks eight ranges, 20 mV to 2.56 V
// - gain factor is 1 on the widest range and 128 on the narrowest
// - auxiliary converter has no gain; fixed 2.50 V range
// - unipolar coding is straight binary
// - bipolar coding is offset binary around mid-scale
// - result width is 24 bits, 16 on the narrow variant
// - unipolar primary code follows input times gain over 1.024 vref
// - auxiliary code follows input over vref; aux_word is stored as received, with no bias added in bipolar mode
// - bipolar primary code is half scale times ratio plus one
// - low four excitation bits enable and route two 200 uA sources
// - primary result held as low, middle and high bytes
// - primary offset and gain coefficients held as three bytes each
// - auxiliary offset and gain coefficients are 16 bits each
// - decimation register sets the sinc filter rate for both converters
// - done flags set on completion, cleared by software or mode write
// - missing reference halts calibration with coefficients untouched
// - offset is subtracted before multiplying by the gain coefficient
`timescale 1ns/1ps
module sd_conv_ctrl #(
    parameter bit NARROW = 1'b0,
    parameter int POWERUP_CYCLES = conv_pkg::POWERUP_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [23:0] filter_word,
    input wire logic filter_valid,
    input wire logic [15:0] aux_word,
    input wire logic aux_valid,
    input wire logic missing_reference_flag,
    output logic [7:0] decimation_factor,
    output logic [3:0] gain_factor_log2,
    output logic [1:0] excitation_pin_one,
    output logic [1:0] excitation_pin_two,
    output logic powered_up
);
    typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_FULL} cal_state_t;

    cal_state_t cal_r;
    logic [7:0] mode_r, ctrl1_r, decim_r, excit_r, status_r;
    logic [23:0] pres_r, poff_r, pgain_r, scaled_r;
    logic [15:0] aoff_r, again_r, ares_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_have_r, w_have_r;
    logic [19:0] pu_cnt_r;
    logic [1:0] pin1_nxt, pin2_nxt;
    logic [23:0] scaled_nxt;

    coef_if cif ();

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // narrow variant: the low byte is absent and reads zero
    function automatic logic [23:0] trim(input logic [23:0] v);
        return NARROW ? {v[23:8], 8'h00} : v;
    endfunction

    wire logic wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    wire logic mode_wr = wr_go && aw_addr_r == conv_pkg::ADDR_MODE
                         && w_strb_r[0];
    wire logic status_wr = wr_go && aw_addr_r == conv_pkg::ADDR_STATUS
                           && w_strb_r[0];
    wire logic [7:0] wmode = 8'(merge({24'h0, mode_r}, w_data_r, w_strb_r));
    wire logic [2:0] new_md = wmode[conv_pkg::MD_LSB +: 3];
    wire logic bipolar = mode_r[conv_pkg::MODE_BIPOLAR_BIT];
    wire logic aux_en = mode_r[conv_pkg::MODE_AUX_BIT];
    wire logic [2:0] range = ctrl1_r[conv_pkg::RANGE_LSB +: 3];
    wire logic pdone = status_r[conv_pkg::ST_PDONE];
    // results are inhibited while the done flag is still set
    wire logic conv_take = filter_valid && !pdone && cal_r == CAL_IDLE;
    wire logic cal_take = filter_valid && !pdone && cal_r != CAL_IDLE;
    wire logic cal_abort = cal_r != CAL_IDLE && missing_reference_flag;
    wire logic aux_take = aux_valid && aux_en
                          && !status_r[conv_pkg::ST_ADONE];
    wire logic wr_known = aw_addr_r <= conv_pkg::ADDR_SCALED
                          && aw_addr_r[1:0] == 2'b00;

    assign cif.raw = filter_word;
    assign cif.offset = poff_r;
    assign cif.gain = pgain_r;
    assign cif.range = range;
    assign cif.bipolar = bipolar;
    assign scaled_nxt = trim(cif.scaled);

    result_scaler u_scaler (
        .c(cif)
    );

    excitation_router u_excit (
        .code(excit_r[3:0]),
        .pin_one_srcs(pin1_nxt),
        .pin_two_srcs(pin2_nxt)
    );

    // axi-lite write channels, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= conv_pkg::AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? conv_pkg::AXI_OKAY
                                        : conv_pkg::AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = clk_en && !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = clk_en && !w_have_r && !s_axi_bvalid;

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= conv_pkg::AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= conv_pkg::AXI_OKAY;
                unique case (s_axi_araddr)
                    conv_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, status_r};
                    conv_pkg::ADDR_MODE: s_axi_rdata <= {24'h0, mode_r};
                    conv_pkg::ADDR_CTRL1: s_axi_rdata <= {24'h0, ctrl1_r};
                    conv_pkg::ADDR_DECIM: s_axi_rdata <= {24'h0, decim_r};
                    conv_pkg::ADDR_EXCIT: s_axi_rdata <= {24'h0, excit_r};
                    conv_pkg::ADDR_PRES: s_axi_rdata <= {8'h0, pres_r};
                    conv_pkg::ADDR_POFF: s_axi_rdata <= {8'h0, poff_r};
                    conv_pkg::ADDR_PGAIN: s_axi_rdata <= {8'h0, pgain_r};
                    conv_pkg::ADDR_AOFF: s_axi_rdata <= {16'h0, aoff_r};
                    conv_pkg::ADDR_AGAIN: s_axi_rdata <= {16'h0, again_r};
                    conv_pkg::ADDR_ARES: s_axi_rdata <= {16'h0, ares_r};
                    conv_pkg::ADDR_SCALED: s_axi_rdata <= {8'h0, scaled_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= conv_pkg::AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = clk_en && !s_axi_rvalid;

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= conv_pkg::MODE_RESET;
            ctrl1_r <= conv_pkg::CTRL1_RESET;
            decim_r <= conv_pkg::DECIM_RESET;
            excit_r <= 8'h00;
        end else if (clk_en && wr_go) begin
            unique case (aw_addr_r)
                conv_pkg::ADDR_MODE:
                    mode_r <= wmode;
                conv_pkg::ADDR_CTRL1:
                    ctrl1_r <= 8'(merge({24'h0, ctrl1_r}, w_data_r, w_strb_r));
                conv_pkg::ADDR_DECIM:
                    decim_r <= 8'(merge({24'h0, decim_r}, w_data_r, w_strb_r));
                conv_pkg::ADDR_EXCIT:
                    excit_r <= 8'(merge({24'h0, excit_r}, w_data_r, w_strb_r))
                               & 8'h0F;
                default: begin
                end
            endcase
        end
    end

    // calibration sequencer and results
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_r <= CAL_IDLE;
            status_r <= 8'h00;
            pres_r <= 24'h00_0000;
            scaled_r <= 24'h00_0000;
            poff_r <= conv_pkg::POFF_RESET;
            pgain_r <= conv_pkg::PGAIN_RESET;
            aoff_r <= conv_pkg::AOFF_RESET;
            again_r <= conv_pkg::AGAIN_RESET;
            ares_r <= 16'h0000;
        end else if (clk_en) begin
            status_r[conv_pkg::ST_NOREF] <= missing_reference_flag;
            if (status_wr) begin
                // software clears done flags by writing zero
                status_r[conv_pkg::ST_PDONE] <= w_data_r[conv_pkg::ST_PDONE]
                                                & pdone;
                status_r[conv_pkg::ST_ADONE] <= w_data_r[conv_pkg::ST_ADONE]
                                 & status_r[conv_pkg::ST_ADONE];
            end
            if (mode_wr) begin
                status_r[conv_pkg::ST_PDONE] <= 1'b0;
                status_r[conv_pkg::ST_ADONE] <= 1'b0;
                status_r[conv_pkg::ST_CAL] <= 1'b0;
                status_r[conv_pkg::ST_ERR] <= 1'b0;
                if (new_md == conv_pkg::MD_SYS_ZERO) begin
                    cal_r <= CAL_ZERO;
                end else if (new_md == conv_pkg::MD_SYS_FULL) begin
                    cal_r <= CAL_FULL;
                end else begin
                    cal_r <= CAL_IDLE;
                end
            end else if (cal_abort) begin
                // no coefficient write on a lost reference
                cal_r <= CAL_IDLE;
                status_r[conv_pkg::ST_ERR] <= 1'b1;
                status_r[conv_pkg::ST_PDONE] <= 1'b1;
            end else if (cal_take) begin
                if (cal_r == CAL_ZERO) begin
                    // bipolar zero lands at mid-scale via the bias
                    poff_r <= trim(filter_word);
                end else begin
                    pgain_r <= trim(filter_word - poff_r);
                end
                cal_r <= CAL_IDLE;
                status_r[conv_pkg::ST_CAL] <= 1'b1;
                status_r[conv_pkg::ST_PDONE] <= 1'b1;
            end else if (conv_take) begin
                pres_r <= trim(filter_word);
                scaled_r <= scaled_nxt;
                status_r[conv_pkg::ST_PDONE] <= 1'b1;
            end
            // fixed-range auxiliary path, no gain stage
            if (aux_take && !mode_wr) begin
                ares_r <= aux_word;
                status_r[conv_pkg::ST_ADONE] <= 1'b1;
            end
        end
    end

    // pin drives and power-up counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            excitation_pin_one <= 2'b00;
            excitation_pin_two <= 2'b00;
            decimation_factor <= conv_pkg::DECIM_RESET;
            gain_factor_log2 <= 4'h0;
            pu_cnt_r <= 20'h0_0000;
            powered_up <= 1'b0;
        end else if (clk_en) begin
            excitation_pin_one <= pin1_nxt;
            excitation_pin_two <= pin2_nxt;
            decimation_factor <= decim_r;
            // range 7 is gain 1, range 0 is gain 128
            gain_factor_log2 <= {1'b0, conv_pkg::RANGE_WIDEST - range};
            // software polls this before trusting results
            if (pu_cnt_r < 20'(POWERUP_CYCLES)) begin
                pu_cnt_r <= pu_cnt_r + 20'h0_0001;
            end else begin
                powered_up <= 1'b1;
            end
        end
    end
endmodule // sd_conv_ctrl

// ===== test/sd_conv_ctrl_props.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module sd_conv_ctrl_props #(
    parameter int POWERUP_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] decimation_factor,
    input wire logic [3:0] gain_factor_log2,
    input wire logic [1:0] excitation_pin_one,
    input wire logic [1:0] excitation_pin_two,
    input wire logic powered_up
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // saturating count since reset; assumes clk_en stays high
    int up_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) up_cnt_r <= 0;
        else if (up_cnt_r < POWERUP_CYCLES + 4) up_cnt_r <= up_cnt_r + 1;
    end
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data late");
    AST_NO_SECOND_AW: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address accepted during pending response");
    AST_RESET_DECIM: assert property ($rose(aresetn) |->
        !powered_up && decimation_factor == conv_pkg::DECIM_RESET)
        else $error("decimation output wrong after reset");
    AST_GAIN_RANGE: assert property ($changed(gain_factor_log2)
        |-> $past(s_axi_bvalid))
        else $error("gain factor changed without a register write");
    AST_EXC_SHARE: assert property (!(excitation_pin_one[0]
        && excitation_pin_two[0]) && !(excitation_pin_one[1]
        && excitation_pin_two[1]))
        else $error("one source driven onto both pins");
    AST_POWER_EARLY: assert property (
        up_cnt_r <= POWERUP_CYCLES |-> !powered_up)
        else $error("powered up too early");
    AST_POWER_LATE: assert property (
        up_cnt_r > POWERUP_CYCLES |-> powered_up)
        else $error("powered up too late");
endmodule // sd_conv_ctrl_props
bind sd_conv_ctrl sd_conv_ctrl_props #(.POWERUP_CYCLES(POWERUP_CYCLES))
    sd_conv_ctrl_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .decimation_factor, .gain_factor_log2,
    .excitation_pin_one, .excitation_pin_two, .powered_up);

// ===== test/sd_conv_ctrl_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module sd_conv_ctrl_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, filter_valid, missing_reference_flag, powered_up;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [1:0] excitation_pin_one, excitation_pin_two;
    logic [31:0] s_axi_rdata, rv, g;
    logic [23:0] filter_word;
    logic [23:0] word = 24'h00_0000;
    logic go = 1'b0, noref = 1'b0, aux_valid = 1'b0;
    logic [15:0] aux_word = 16'h0000;
    logic [7:0] decimation_factor;
    logic [3:0] gain_factor_log2;
    int bad_count = 0, num_checks = 0, cycles = 0;
    localparam logic [1:0] OK = conv_pkg::AXI_OKAY;

    sd_conv_ctrl #(.NARROW(1'b0), .POWERUP_CYCLES(20)) sd_conv_ctrl_i (
        .aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filter_word,
        .filter_valid, .aux_word, .aux_valid,
        .missing_reference_flag, .decimation_factor, .gain_factor_log2,
        .excitation_pin_one, .excitation_pin_two, .powered_up);
    sensor_model sensor_model_i (.aclk, .aresetn, .go, .word, .noref,
        .filter_word, .filter_valid, .missing_reference_flag);

    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string nm);
        rd(a);
        `CHK(nm, e, rv)
    endtask
    task automatic send(input logic [23:0] w);
        @(posedge aclk);
        word <= w;
        go <= 1'b1;
        aux_word <= w[23:8];
        aux_valid <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        aux_valid <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(conv_pkg::ADDR_STATUS);
            n++;
        end while (rv[conv_pkg::ST_PDONE] !== 1'b1 && n < 40);
    endtask
    task automatic settle;
        @(posedge aclk);
        #1;
    endtask

    task automatic t_power;
        `CHK("up early", 1'b0, powered_up)
        repeat (30) @(posedge aclk);
        `CHK("up late", 1'b1, powered_up)
    endtask
    task automatic t_reset_values;
        rdchk(conv_pkg::ADDR_MODE, 32'(conv_pkg::MODE_RESET), "mode");
        rdchk(conv_pkg::ADDR_CTRL1, 32'(conv_pkg::CTRL1_RESET), "ctrl1");
        rdchk(conv_pkg::ADDR_DECIM, 32'(conv_pkg::DECIM_RESET), "decim");
        rdchk(conv_pkg::ADDR_PGAIN, 32'h0080_0000, "pgain");
        rdchk(conv_pkg::ADDR_AGAIN, 32'h0000_8000, "again");
        wr(conv_pkg::ADDR_DECIM, 32'h0000_0010, OK);
        settle();
        `CHK("decim out", 8'h10, decimation_factor)
    endtask
    task automatic t_unmapped;
        wr(8'h30, 32'h0000_00ff, conv_pkg::AXI_SLVERR);
        rd(8'h30);
        `CHK("rresp", conv_pkg::AXI_SLVERR, rr)
        `CHK("rdata", 32'h0000_0000, rv)
    endtask
    task automatic t_ranges;
        for (int i = 0; i < 8; i++) begin
            wr(conv_pkg::ADDR_CTRL1, 32'(i), OK);
            settle();
            `CHK("gain", 4'(7 - i), gain_factor_log2)
        end
    endtask
    task automatic t_excitation;
        for (int a = 0; a < 3; a++) begin
            for (int b = 0; b < 3; b++) begin
                wr(conv_pkg::ADDR_EXCIT, 32'(b * 4 + a), OK);
                settle();
                `CHK("pin1", {b==1, a==1}, excitation_pin_one)
                `CHK("pin2", {b==2, a==2}, excitation_pin_two)
            end
        end
    endtask
    task automatic t_cal_unipolar;
        wr(conv_pkg::ADDR_MODE, 32'(conv_pkg::MD_SYS_ZERO), OK);
        send(24'h00_1000);
        wait_done();
        `CHK("cal", 1'b1, rv[conv_pkg::ST_CAL])
        rdchk(conv_pkg::ADDR_POFF, 32'h0000_1000, "poff");
        wr(conv_pkg::ADDR_MODE, 32'(conv_pkg::MD_SYS_FULL), OK);
        send(24'h40_1000);
        wait_done();
        rdchk(conv_pkg::ADDR_PGAIN, 32'h0040_0000, "pgain");
        wr(conv_pkg::ADDR_MODE, 32'(conv_pkg::MD_IDLE), OK);
        rd(conv_pkg::ADDR_STATUS);
        `CHK("flags", 3'b000, rv[7:5])
        send(24'h00_1000);
        wait_done();
        rdchk(conv_pkg::ADDR_SCALED, 32'h0, "uni");
        wr(conv_pkg::ADDR_STATUS, 32'h0000_0000, OK);
        rd(conv_pkg::ADDR_STATUS);
        `CHK("sw clear", 1'b0, rv[conv_pkg::ST_PDONE])
    endtask
    task automatic t_cal_bipolar;
        wr(conv_pkg::ADDR_MODE, 32'h0000_0016, OK);
        send(24'h80_2000);
        wait_done();
        wr(conv_pkg::ADDR_MODE, 32'h0000_0030, OK);
        send(24'h80_2000);
        wait_done();
        rdchk(conv_pkg::ADDR_SCALED, 32'h80_0000, "bip");
        rdchk(conv_pkg::ADDR_ARES, 32'h0000_8020, "ares");
    endtask
    task automatic t_noref;
        rd(conv_pkg::ADDR_PGAIN);
        g = rv;
        wr(conv_pkg::ADDR_MODE, 32'(conv_pkg::MD_SYS_FULL), OK);
        @(posedge aclk);
        noref <= 1'b1;
        wait_done();
        `CHK("err", 1'b1, rv[conv_pkg::ST_ERR])
        rdchk(conv_pkg::ADDR_PGAIN, g, "kept");
        @(posedge aclk);
        noref <= 1'b0;
        wr(conv_pkg::ADDR_MODE, 32'(conv_pkg::MD_IDLE), OK);
        rd(conv_pkg::ADDR_STATUS);
        `CHK("err clr", 2'b00, {rv[7], rv[3]})
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        t_power();
        t_reset_values();
        t_unmapped();
        t_ranges();
        t_excitation();
        // calibrate on the range later conversions use
        wr(conv_pkg::ADDR_CTRL1, 32'(conv_pkg::RANGE_WIDEST), OK);
        t_cal_unipolar();
        t_cal_bipolar();
        t_noref();
        complete_run();
    end
endmodule // sd_conv_ctrl_tb_top

// ===== test/sensor_model.sv
// sensor-side model: delivers filter words and the reference status
`timescale 1ns/1ps
module sensor_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [23:0] word,
    input wire logic noref,
    output logic [23:0] filter_word,
    output logic filter_valid,
    output logic missing_reference_flag
);
    // lines toggle between words so a late sample is caught
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_word <= 24'h00_0000;
            filter_valid <= 1'b0;
            missing_reference_flag <= 1'b0;
        end else begin
            filter_valid <= go;
            filter_word <= go ? word : ~filter_word;
            missing_reference_flag <= noref;
        end
    end
endmodule // sensor_model
